// >>> logic/esar_pkg.sv
// constants for the e1 status and alarm register bank
// assumes a 25 MHz system clock and an 8-bit host control port
package esar_pkg;

   // register addresses on the control port
   localparam logic [7:0] ADDR_ALARM_STAT = 8'h06;
   localparam logic [7:0] ADDR_EVENT_STAT = 8'h07;
   localparam logic [7:0] ADDR_INFO_STAT = 8'h08;
   localparam logic [7:0] ADDR_ALARM_MASK = 8'h16;
   localparam logic [7:0] ADDR_EVENT_MASK = 8'h17;
   localparam logic [7:0] ADDR_SYNC_STAT = 8'h1E;

   // receive_alarm_status bit positions
   localparam int BIT_SIG_ALL_ONES = 7;
   localparam int BIT_DISTANT_MF = 6;
   localparam int BIT_SIG_ALL_ZEROS = 5;
   localparam int BIT_RX_SLIP = 4;
   localparam int BIT_UNFRAMED_ONES = 3;
   localparam int BIT_REMOTE_ALARM = 2;
   localparam int BIT_CARRIER_LOSS = 1;
   localparam int BIT_SYNC_LOSS = 0;

   // values after reset, and read data of unmapped addresses
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] RDATA_RST = 8'h00;
   localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

   // carrier loss: zero run to set, window and ones count to release
   localparam logic [7:0] CL_ZERO_RUN = 8'hFF;
   localparam logic [7:0] CL_WIN_BITS = 8'hFF;
   localparam logic [5:0] CL_MIN_ONES = 6'h20;

   // unframed all ones: window of two frames, fewer than 3 zeros
   localparam logic [8:0] UA_WIN_BITS = 9'h1FF;
   localparam logic [1:0] UA_MAX_ZEROS = 2'h3;

   // remote alarm: consecutive agreeing occasions to change state
   localparam logic [1:0] RA_RUN = 2'h3;

   // crc4 multiframe search window
   localparam int CLK_HZ = 25_000_000;
   localparam int SEARCH_WIN_MS = 8;
   localparam int SEARCH_WIN_CYC = CLK_HZ / 1000 * SEARCH_WIN_MS;

   typedef enum logic {CL_PRESENT, CL_LOST} esar_cl_state_t;

endpackage

// >>> logic/esar_latch_reg.sv
// one latched status register: sticky flags plus a host-visible copy
// assumes i_wr is a one-cycle strobe already decoded for this register
`timescale 1ns/1ns
`default_nettype none
module esar_latch_reg (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_set,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_flags,
   output logic [7:0] o_read_copy
);
   import esar_pkg::*;

   logic [7:0] flags_ff;
   logic [7:0] copy_ff;
   logic [7:0] nxt_flags;
   logic [7:0] nxt_copy;

   // set beats a clearing write in the same cycle
   always_comb begin
      nxt_flags = i_wr ? (flags_ff & ~i_wdata) : flags_ff;
      nxt_flags = nxt_flags | i_set;
   end

   // ones refresh the copy, zeros keep it
   always_comb begin
      nxt_copy = copy_ff;
      if (i_wr) begin
         nxt_copy = (i_wdata & (flags_ff | i_set))
                  | (~i_wdata & copy_ff);
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         flags_ff <= STAT_RST;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         copy_ff <= STAT_RST;
      end else begin
         copy_ff <= nxt_copy;
      end
   end

   assign o_flags = flags_ff;
   assign o_read_copy = copy_ff;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   AST_SET_STICKS: assert property (
      (|i_set) |=> ((flags_ff & $past(i_set)) == $past(i_set)))
      else $error("event did not latch");
   AST_HOLD_UNTIL_CLEAR: assert property (
      !i_wr |=> ((flags_ff & $past(flags_ff)) == $past(flags_ff)))
      else $error("flag dropped without a clearing write");
   AST_CLEAR_ON_ONE: assert property (
      (i_wr && i_set == 8'h00) |=> ((flags_ff & $past(i_wdata)) == 8'h00)
         && ((copy_ff & $past(i_wdata))
             == ($past(flags_ff) & $past(i_wdata))))
      else $error("selected bit not captured and cleared");
   AST_HOLD_ON_ZERO: assert property (
      i_wr |=> ((copy_ff & ~$past(i_wdata))
                == ($past(copy_ff) & ~$past(i_wdata))))
      else $error("unselected copy bit changed");

endmodule
`default_nettype wire

// >>> logic/esar_top.sv
// status, information and synchronizer registers of an e1 receiver
// assumes all inputs synchronous to I_CLK; I_WR/I_RD one-cycle strobes;
// I_RX_BIT_EN pulses once per received bit
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - latched status bits stay one after their event until the host writes one to them
// - after clearing, a bit sets again only on new event or alarm
// - writing one to a bit refreshes its copy and clears the flag
// - writing zero to a bit keeps its copy unchanged
// - synchronizer status is read-only, live, needs no preceding write
// - alarm flags drive first irq pin, event flags second, masked per bit
// - sync status bits 7..3 show counter bits 5,4,3,2,0
// - counter bit 1 hidden; visible lsb toggles each 8 ms timeout
// - sync status bit 2 is one while seeking frame alignment
// - sync status bit 1 is one while seeking signaling multiframe
// - search counter increments each 8 ms timeout and wraps
// - search counter clears when crc4 multiframe sync is reached
// - turning crc4 mode off clears the search counter
// - bit 7 latches on timeslot 16 with fewer than three zeros
// - bit 6 latches on distant multiframe alarm, also in ccs mode
// - bit 5 latches when timeslot 16 is all zeros for a multiframe
// - bit 4 latches when receive elastic store slips a frame
// - bits 3 and 2 latch on unframed all ones and remote alarm
// - bit 1 latches after 255 consecutive zeros on the line
// - bit 0 is set while receive framer is out of sync
// - all ones: fewer than 3 zeros in 512 bits, release above 2
// - remote alarm: three ones to assert, three zeros to release
// - carrier loss releases on 32 ones within 255 bit times
module esar_top #(
   parameter int P_SEARCH_WIN_CYC = esar_pkg::SEARCH_WIN_CYC
) (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   input wire logic I_CRC_MODE_ENABLE,
   input wire logic I_RX_BIT,
   input wire logic I_RX_BIT_EN,
   input wire logic I_NAF_STROBE,
   input wire logic I_NAF_BIT3,
   input wire logic I_SIG_ALL_ONES,
   input wire logic I_DISTANT_MF_ALARM,
   input wire logic I_SIG_ALL_ZEROS,
   input wire logic I_RX_STORE_SLIP,
   input wire logic I_SYNC_LOSS,
   input wire logic [7:0] I_FRAME_EVENTS,
   input wire logic [7:0] I_RX_INFO_EVENTS,
   input wire logic I_FRAME_SEARCH,
   input wire logic I_SIGMF_SEARCH,
   input wire logic I_CRCMF_SEARCH,
   input wire logic I_CRC_SYNC_OK,
   output logic O_ALARM_IRQ_N,
   output logic O_EVENT_IRQ_N
);
   import esar_pkg::*;

   logic wr_alarm;
   logic wr_event;
   logic wr_info;
   logic [7:0] alarm_set;
   logic [7:0] alarm_flags;
   logic [7:0] alarm_copy;
   logic [7:0] event_flags;
   logic [7:0] event_copy;
   logic [7:0] info_flags;
   logic [7:0] info_copy;
   logic [7:0] alarm_mask_ff;
   logic [7:0] event_mask_ff;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic [7:0] sync_stat;
   logic alarm_irq_n_ff;
   logic event_irq_n_ff;

   assign wr_alarm = I_WR && (I_ADDR == ADDR_ALARM_STAT);
   assign wr_event = I_WR && (I_ADDR == ADDR_EVENT_STAT);
   assign wr_info = I_WR && (I_ADDR == ADDR_INFO_STAT);

   // ---- carrier loss detector
   esar_cl_state_t cl_state_ff;
   logic [7:0] zero_run_ff;
   logic [7:0] cl_win_ff;
   logic [5:0] cl_ones_ff;
   logic [5:0] nxt_cl_ones;
   logic cl_start;
   logic cl_win_end;

   assign cl_start = I_RX_BIT_EN && !I_RX_BIT
                     && (zero_run_ff == 8'(CL_ZERO_RUN - 8'h01));
   assign cl_win_end = I_RX_BIT_EN
                       && (cl_win_ff == 8'(CL_WIN_BITS - 8'h01));
   assign nxt_cl_ones = (I_RX_BIT && cl_ones_ff != CL_MIN_ONES)
                        ? 6'(cl_ones_ff + 6'h01) : cl_ones_ff;

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         zero_run_ff <= 8'h00;
      end else if (I_RX_BIT_EN) begin
         if (I_RX_BIT) begin
            zero_run_ff <= 8'h00;
         end else if (zero_run_ff != CL_ZERO_RUN) begin
            zero_run_ff <= 8'(zero_run_ff + 8'h01);
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         cl_state_ff <= CL_PRESENT;
         cl_win_ff <= 8'h00;
         cl_ones_ff <= 6'h00;
      end else begin
         case (cl_state_ff)
            CL_PRESENT: begin
               cl_win_ff <= 8'h00;
               cl_ones_ff <= 6'h00;
               if (cl_start) begin
                  cl_state_ff <= CL_LOST;
               end
            end
            CL_LOST: begin
               if (cl_win_end) begin
                  cl_win_ff <= 8'h00;
                  cl_ones_ff <= 6'h00;
                  if (nxt_cl_ones == CL_MIN_ONES) begin
                     cl_state_ff <= CL_PRESENT;
                  end
               end else if (I_RX_BIT_EN) begin
                  cl_win_ff <= 8'(cl_win_ff + 8'h01);
                  cl_ones_ff <= nxt_cl_ones;
               end
            end
            default: begin
               cl_state_ff <= CL_PRESENT;
            end
         endcase
      end
   end

   // ---- unframed all ones detector, fixed 512-bit windows
   logic [8:0] ua_win_ff;
   logic [1:0] ua_zeros_ff;
   logic [1:0] nxt_ua_zeros;
   logic ua_cond_ff;

   assign nxt_ua_zeros = (!I_RX_BIT && ua_zeros_ff != UA_MAX_ZEROS)
                         ? 2'(ua_zeros_ff + 2'h1) : ua_zeros_ff;

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         ua_win_ff <= 9'h000;
         ua_zeros_ff <= 2'h0;
         ua_cond_ff <= 1'b0;
      end else if (I_RX_BIT_EN) begin
         if (ua_win_ff == UA_WIN_BITS) begin
            ua_cond_ff <= (nxt_ua_zeros != UA_MAX_ZEROS);
            ua_win_ff <= 9'h000;
            ua_zeros_ff <= 2'h0;
         end else begin
            ua_win_ff <= 9'(ua_win_ff + 9'h001);
            ua_zeros_ff <= nxt_ua_zeros;
         end
      end
   end

   // ---- remote alarm: three agreeing occasions flip the state
   logic [1:0] ra_run_ff;
   logic ra_cond_ff;

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         ra_run_ff <= 2'h0;
         ra_cond_ff <= 1'b0;
      end else if (I_NAF_STROBE) begin
         if (I_NAF_BIT3 == ra_cond_ff) begin
            ra_run_ff <= 2'h0;
         end else if (ra_run_ff == 2'(RA_RUN - 2'h1)) begin
            ra_cond_ff <= I_NAF_BIT3;
            ra_run_ff <= 2'h0;
         end else begin
            ra_run_ff <= 2'(ra_run_ff + 2'h1);
         end
      end
   end

   // ---- crc4 search window timer and search counter
   logic [17:0] win_tmr_ff;
   logic [5:0] search_cnt_ff;
   logic win_expire;

   assign win_expire = I_CRC_MODE_ENABLE && I_CRCMF_SEARCH
                       && (win_tmr_ff == 18'(P_SEARCH_WIN_CYC - 1));

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         win_tmr_ff <= 18'h00000;
      end else if (!I_CRC_MODE_ENABLE || !I_CRCMF_SEARCH || win_expire) begin
         win_tmr_ff <= 18'h00000;
      end else begin
         win_tmr_ff <= 18'(win_tmr_ff + 18'h00001);
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         search_cnt_ff <= 6'h00;
      end else if (!I_CRC_MODE_ENABLE || I_CRC_SYNC_OK) begin
         search_cnt_ff <= 6'h00;
      end else if (win_expire) begin
         search_cnt_ff <= 6'(search_cnt_ff + 6'h01);
      end
   end

   // live view, bit 1 of the counter is not shown
   assign sync_stat = {search_cnt_ff[5:2], search_cnt_ff[0],
                       I_FRAME_SEARCH,
                       I_SIGMF_SEARCH,
                       I_CRCMF_SEARCH};

   // ---- latched registers
   always_comb begin
      alarm_set = 8'h00;
      alarm_set[BIT_SIG_ALL_ONES] = I_SIG_ALL_ONES;
      alarm_set[BIT_DISTANT_MF] = I_DISTANT_MF_ALARM;
      alarm_set[BIT_SIG_ALL_ZEROS] = I_SIG_ALL_ZEROS;
      alarm_set[BIT_RX_SLIP] = I_RX_STORE_SLIP;
      alarm_set[BIT_UNFRAMED_ONES] = ua_cond_ff;
      alarm_set[BIT_REMOTE_ALARM] = ra_cond_ff;
      alarm_set[BIT_CARRIER_LOSS] = (cl_state_ff == CL_LOST);
      alarm_set[BIT_SYNC_LOSS] = I_SYNC_LOSS;
   end

   esar_latch_reg u_alarm_stat (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_set(alarm_set),
      .i_wr(wr_alarm),
      .i_wdata(I_WDATA),
      .o_flags(alarm_flags),
      .o_read_copy(alarm_copy)
   );

   esar_latch_reg u_event_stat (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_set(I_FRAME_EVENTS),
      .i_wr(wr_event),
      .i_wdata(I_WDATA),
      .o_flags(event_flags),
      .o_read_copy(event_copy)
   );

   esar_latch_reg u_info_stat (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_set(I_RX_INFO_EVENTS),
      .i_wr(wr_info),
      .i_wdata(I_WDATA),
      .o_flags(info_flags),
      .o_read_copy(info_copy)
   );

   // ---- interrupt masks
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         alarm_mask_ff <= MASK_RST;
      end else if (I_WR && I_ADDR == ADDR_ALARM_MASK) begin
         alarm_mask_ff <= I_WDATA;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         event_mask_ff <= MASK_RST;
      end else if (I_WR && I_ADDR == ADDR_EVENT_MASK) begin
         event_mask_ff <= I_WDATA;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         alarm_irq_n_ff <= 1'b1;
         event_irq_n_ff <= 1'b1;
      end else begin
         alarm_irq_n_ff <= ~|(alarm_flags & alarm_mask_ff);
         event_irq_n_ff <= ~|(event_flags & event_mask_ff);
      end
   end

   // ---- read port, sync status needs no prior write
   always_comb begin
      case (I_ADDR)
         ADDR_ALARM_STAT: nxt_rdata = alarm_copy;
         ADDR_EVENT_STAT: nxt_rdata = event_copy;
         ADDR_INFO_STAT: nxt_rdata = info_copy;
         ADDR_ALARM_MASK: nxt_rdata = alarm_mask_ff;
         ADDR_EVENT_MASK: nxt_rdata = event_mask_ff;
         ADDR_SYNC_STAT: nxt_rdata = sync_stat;
         default: nxt_rdata = UNMAPPED_RDATA;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         rdata_ff <= RDATA_RST;
      end else if (I_RD) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign O_RDATA = rdata_ff;
   assign O_ALARM_IRQ_N = alarm_irq_n_ff;
   assign O_EVENT_IRQ_N = event_irq_n_ff;

   // ---- checks
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);

   AST_SYNC_STAT_MAP: assert property (
      (I_RD && I_ADDR == ADDR_SYNC_STAT) |=> O_RDATA ==
         $past({search_cnt_ff[5:2], search_cnt_ff[0],
                I_FRAME_SEARCH, I_SIGMF_SEARCH, I_CRCMF_SEARCH}))
      else $error("sync status read mismatch");
   AST_CNT_STEP: assert property (
      (I_CRC_MODE_ENABLE && !I_CRC_SYNC_OK && win_expire)
         |=> search_cnt_ff == 6'($past(search_cnt_ff) + 6'h01))
      else $error("search counter did not step");
   AST_CNT_CLEAR: assert property (
      (!I_CRC_MODE_ENABLE || I_CRC_SYNC_OK) |=> search_cnt_ff == 6'h00)
      else $error("search counter not cleared");
   AST_CL_SET: assert property (
      cl_start |=> (cl_state_ff == CL_LOST) ##1 alarm_flags[BIT_CARRIER_LOSS])
      else $error("carrier loss not latched");
   AST_CL_RELEASE: assert property (
      (cl_state_ff == CL_LOST && cl_win_end && nxt_cl_ones == CL_MIN_ONES)
         |=> cl_state_ff == CL_PRESENT)
      else $error("carrier loss not released");
   AST_UA_EVAL: assert property (
      (I_RX_BIT_EN && ua_win_ff == UA_WIN_BITS)
         |=> ua_cond_ff == ($past(nxt_ua_zeros) != UA_MAX_ZEROS))
      else $error("unframed ones decision wrong");
   AST_RA_ASSERT: assert property (
      (I_NAF_STROBE && I_NAF_BIT3 && !ra_cond_ff && ra_run_ff == 2'h2)
         |=> ra_cond_ff)
      else $error("remote alarm not asserted");
   AST_ALARM_IRQ: assert property (
      (|(alarm_flags & alarm_mask_ff)) |=> !O_ALARM_IRQ_N)
      else $error("alarm irq not driven");
   AST_EVENT_IRQ: assert property (
      (event_mask_ff == 8'h00) |=> O_EVENT_IRQ_N)
      else $error("event irq active while fully masked");
   AST_LOS_LATCH: assert property (
      I_SYNC_LOSS |=> alarm_flags[BIT_SYNC_LOSS])
      else $error("sync loss not latched");

   COV_CL_LOST: cover property (cl_start);
   COV_CNT_WRAP: cover property (win_expire && search_cnt_ff == 6'h3F);
   COV_IRQ: cover property ($fell(O_ALARM_IRQ_N));
   COV_SYNC_READ: cover property (I_RD && I_ADDR == ADDR_SYNC_STAT);

endmodule
`default_nettype wire

// >>> tb/esar_host.sv
// host model: byte-wide master of the register port
// assumes esar_top port timing: one-cycle strobes, data one edge late
`timescale 1ns/1ns
`default_nettype none
module esar_host (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_wr,
   output logic o_rd
);
   initial begin
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      // released data does not keep its last value
      o_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      @(posedge i_clk);
      #1;
      d = i_rdata;
   endtask
   // select, read, write back so selected bits really clear
   task automatic poll(input logic [7:0] a, input logic [7:0] m,
                       output logic [7:0] d);
      wr(a, m);
      rd(a, d);
      wr(a, d & m);
   endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench of the status and alarm register bank
// assumes esar_top with a 20-cycle search window, host model in esar_host
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import esar_pkg::*;
   localparam int WIN = 20;
   localparam int LIMIT = 20000;
   logic clk, rst_n, crc_en, rx_bit, rx_en, naf_stb, naf_b3, csync;
   logic fsrch, ssrch, csrch, wr, rd, alarm_n, event_n;
   logic [4:0] al;
   logic [7:0] fev, riev, addr, wdata, rdata, d;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int t0 = 0;
   int pos[5] = '{0, 4, 5, 6, 7};
   esar_top #(.P_SEARCH_WIN_CYC(WIN)) DUT (.I_CLK(clk), .I_RST_N(rst_n),
      .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
      .I_CRC_MODE_ENABLE(crc_en), .I_RX_BIT(rx_bit), .I_RX_BIT_EN(rx_en),
      .I_NAF_STROBE(naf_stb), .I_NAF_BIT3(naf_b3),
      .I_SIG_ALL_ONES(al[4]), .I_DISTANT_MF_ALARM(al[3]),
      .I_SIG_ALL_ZEROS(al[2]), .I_RX_STORE_SLIP(al[1]),
      .I_SYNC_LOSS(al[0]), .I_FRAME_EVENTS(fev), .I_RX_INFO_EVENTS(riev),
      .I_FRAME_SEARCH(fsrch), .I_SIGMF_SEARCH(ssrch),
      .I_CRCMF_SEARCH(csrch), .I_CRC_SYNC_OK(csync),
      .O_ALARM_IRQ_N(alarm_n), .O_EVENT_IRQ_N(event_n));
   esar_host host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
      .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic t_reset();
      chk({6'h00, alarm_n, event_n}, 8'h03);
      host.rd(ADDR_SYNC_STAT, d);
      chk(d, 8'h00);
      host.rd(8'h55, d);
      chk(d, UNMAPPED_RDATA);
      host.rd(ADDR_ALARM_MASK, d);
      chk(d, MASK_RST);
   endtask
   task automatic t_alarms();
      for (int i = 0; i < 5; i++) begin
         @(posedge clk) al[i] <= 1'b1;
         @(posedge clk) al[i] <= 1'b0;
         idle(6);
         host.poll(ADDR_ALARM_STAT, 8'h01 << pos[i], d);
         chk(d, 8'h01 << pos[i]);
      end
      @(posedge clk) al[1] <= 1'b1;
      @(posedge clk) al[1] <= 1'b0;
      idle(10);
      host.wr(ADDR_ALARM_STAT, 8'h00);
      host.rd(ADDR_ALARM_STAT, d);
      chk(d, 8'h00);
      host.wr(ADDR_ALARM_STAT, 8'h10);
      host.rd(ADDR_ALARM_STAT, d);
      chk(d, 8'h10);
      host.wr(ADDR_ALARM_STAT, 8'h00);
      host.rd(ADDR_ALARM_STAT, d);
      chk(d, 8'h10);
      host.wr(ADDR_ALARM_STAT, 8'h10);
      host.rd(ADDR_ALARM_STAT, d);
      chk(d, 8'h00);
   endtask
   task automatic t_irq();
      host.wr(ADDR_ALARM_MASK, 8'h01);
      @(posedge clk) al[0] <= 1'b1;
      idle(3);
      chk({7'h00, alarm_n}, 8'h00);
      host.poll(ADDR_ALARM_STAT, 8'h01, d);
      host.poll(ADDR_ALARM_STAT, 8'h01, d);
      chk(d, 8'h01);
      @(posedge clk) al[0] <= 1'b0;
      host.poll(ADDR_ALARM_STAT, 8'h01, d);
      host.poll(ADDR_ALARM_STAT, 8'h01, d);
      chk(d, 8'h00);
      idle(3);
      chk({7'h00, alarm_n}, 8'h01);
      host.wr(ADDR_EVENT_MASK, 8'h80);
      host.rd(ADDR_ALARM_MASK, d);
      chk(d, 8'h01);
      host.rd(ADDR_EVENT_MASK, d);
      chk(d, 8'h80);
      @(posedge clk) fev <= 8'h01;
      @(posedge clk) fev <= 8'h00;
      idle(3);
      chk({7'h00, event_n}, 8'h01);
      @(posedge clk) fev <= 8'h80;
      @(posedge clk) fev <= 8'h00;
      idle(3);
      chk({6'h00, alarm_n, event_n}, 8'h02);
      host.poll(ADDR_EVENT_STAT, 8'hFF, d);
      chk(d, 8'h81);
      idle(3);
      chk({7'h00, event_n}, 8'h01);
   endtask
   task automatic t_info();
      @(posedge clk) riev <= 8'hA5;
      @(posedge clk) riev <= 8'h00;
      host.poll(ADDR_INFO_STAT, 8'hFF, d);
      chk(d, 8'hA5);
   endtask
   task automatic feed(input int n, input logic v);
      repeat (n) begin
         @(posedge clk);
         rx_bit <= v;
         rx_en <= 1'b1;
      end
      @(posedge clk);
      rx_en <= 1'b0;
      rx_bit <= ~v;
   endtask
   task automatic t_line();
      feed(254, 1'b0);
      host.poll(ADDR_ALARM_STAT, 8'h02, d);
      chk(d, 8'h00);
      feed(1, 1'b0);
      idle(3);
      host.poll(ADDR_ALARM_STAT, 8'h02, d);
      chk(d, 8'h02);
      feed(800, 1'b1);
      host.poll(ADDR_ALARM_STAT, 8'h02, d);
      host.poll(ADDR_ALARM_STAT, 8'h02, d);
      chk(d, 8'h00);
      host.poll(ADDR_ALARM_STAT, 8'h08, d);
      chk(d, 8'h08);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         naf_stb <= 1'b1;
         naf_b3 <= 1'b1;
         @(posedge clk);
         naf_stb <= 1'b0;
         naf_b3 <= 1'b0;
         idle(3);
         host.poll(ADDR_ALARM_STAT, 8'h04, d);
         // unframed ones bit is written zero here, so its copy keeps its earlier one
         chk(d, (i == 2) ? 8'h0C : 8'h08);
      end
   endtask
   task automatic sync_at(input int k, input logic [7:0] exp);
      idle(t0 + WIN * k + 8 - cyc);
      host.rd(ADDR_SYNC_STAT, d);
      chk(d, exp);
   endtask
   task automatic t_sync();
      host.wr(ADDR_SYNC_STAT, 8'hFF);
      @(posedge clk);
      crc_en <= 1'b1;
      fsrch <= 1'b1;
      csrch <= 1'b1;
      t0 = cyc;
      sync_at(3, 8'h0D);
      sync_at(6, 8'h15);
      sync_at(7, 8'h1D);
      sync_at(65, 8'h0D);
      @(posedge clk);
      csrch <= 1'b0;
      csync <= 1'b1;
      fsrch <= 1'b0;
      ssrch <= 1'b1;
      @(posedge clk) csync <= 1'b0;
      host.rd(ADDR_SYNC_STAT, d);
      chk(d, 8'h02);
      @(posedge clk) csrch <= 1'b1;
      t0 = cyc;
      sync_at(3, 8'h0B);
      @(posedge clk) crc_en <= 1'b0;
      host.rd(ADDR_SYNC_STAT, d);
      chk(d, 8'h03);
   endtask
   initial begin
      {rst_n, crc_en, rx_bit, rx_en, naf_stb, naf_b3, csync} = 7'h00;
      {fsrch, ssrch, csrch, al, fev, riev} = 24'h000000;
      idle(4);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      t_reset();
      t_alarms();
      t_irq();
      t_info();
      t_line();
      t_sync();
      print_verdict();
   end
endmodule
`default_nettype wire
